// ==== nfpi_pkg.sv ====
// Shared constants, commands and state types of the NAND flash pin controller.
// Assumes a 50 MHz core clock; the pin timing counts in cycles derive from that period, except RD_HIGH_CYC.
package nfpi_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int SYNC_STAGES   = 2;

  // Pin timing in nanoseconds, each turned into whole clock cycles (rounded up).
  localparam int T_RC_NS  = 30;
  localparam int T_WP_NS  = 25;
  localparam int T_WH_NS  = 15;
  localparam int T_WB_NS  = 100;
  localparam int RC_CYC   = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC   = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WH_CYC   = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WB_CYC   = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // The read strobe stays low long enough for the byte to cross the synchroniser.
  localparam int RD_LOW_CYC  = RC_CYC + SYNC_STAGES;
  localparam int RD_HIGH_CYC = 1;

  // Busy times that the array may take: longest for page read, typical for program and erase.
  localparam int T_READ_MAX_US  = 35;
  localparam int T_PROG_TYP_US  = 250;
  localparam int T_ERASE_TYP_MS = 2;
  localparam int BUSY_LIMIT_DEF = 500000;

  // Array geometry.
  localparam int PAGE_MAIN   = 2048;
  localparam int PAGE_SPARE  = 64;
  localparam int PAGE_BYTES  = PAGE_MAIN + PAGE_SPARE;
  localparam int PAGE_COUNT  = 65536;
  localparam int BLOCK_PAGES = 64;
  localparam int COL_W       = 12;
  localparam int ROW_W       = 16;
  localparam int ECC_CHUNK   = 528;
  localparam int ECC_W       = 14;
  localparam int STATUS_FAIL_BIT = 0;

  localparam logic [7:0] CMD_READ1  = 8'h00;
  localparam logic [7:0] CMD_READ2  = 8'h30;
  localparam logic [7:0] CMD_PROG1  = 8'h80;
  localparam logic [7:0] CMD_PROG2  = 8'h10;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hd0;
  localparam logic [7:0] CMD_RESET  = 8'hff;
  localparam logic [7:0] CMD_STATUS = 8'h70;

  typedef enum logic [1:0] {
    OP_READ  = 2'b00,
    OP_PROG  = 2'b01,
    OP_ERASE = 2'b10,
    OP_RESET = 2'b11
  } nfpi_op_e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_WLOW  = 4'h1,
    ST_WHIGH = 4'h2,
    ST_DWAIT = 4'h3,
    ST_WAITB = 4'h4,
    ST_BUSY  = 4'h5,
    ST_RLOW  = 4'h6,
    ST_RHIGH = 4'h7,
    ST_DONE  = 4'h8
  } nfpi_state_e;

  typedef enum logic [2:0] {
    PH_CMD1  = 3'h0,
    PH_ADDR  = 3'h1,
    PH_DATA  = 3'h2,
    PH_CMD2  = 3'h3,
    PH_STATC = 3'h4,
    PH_STATR = 3'h5,
    PH_DOUT  = 3'h6
  } nfpi_phase_e;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic [7:0] data_pins_o;
    logic       data_pins_oe;
  } nfpi_pins_s;

  typedef struct packed {
    nfpi_state_e       st;
    nfpi_phase_e       ph;
    nfpi_op_e          opc;
    logic [19:0]       cnt;
    logic [COL_W-1:0]  left;
    logic [1:0]        aidx;
    logic [COL_W-1:0]  col;
    logic [ROW_W-1:0]  row;
    nfpi_pins_s        pins;
    logic              op_ready;
    logic              wr_ready;
    logic [7:0]        rd_data;
    logic              rd_valid;
    logic              done;
    logic              fail;
    logic [9:0]        echk;
    logic [ECC_W-1:0]  eacc;
    logic [ECC_W-1:0]  ecode;
    logic              evalid;
  } nfpi_state_s;

  localparam nfpi_pins_s PINS_RST = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                      read_strobe_n: 1'b1, wp_n: 1'b0,
                                      data_pins_o: 8'h00, data_pins_oe: 1'b0};

  localparam nfpi_state_s STATE_RST = '{st: ST_IDLE, ph: PH_CMD1, opc: OP_READ,
                                        cnt: 20'h00000, left: 12'h000, aidx: 2'h0,
                                        col: 12'h000, row: 16'h0000, pins: PINS_RST,
                                        op_ready: 1'b1, wr_ready: 1'b0, rd_data: 8'h00,
                                        rd_valid: 1'b0, done: 1'b0, fail: 1'b0,
                                        echk: 10'h000, eacc: 14'h0000, ecode: 14'h0000,
                                        evalid: 1'b0};

endpackage

// ==== nfpi_sync.sv ====
// Two-stage synchroniser for the pins that the flash drives back to the controller.
// Assumes its input is asynchronous to core_clk; only the second stage is read.
`timescale 1ns/100ps
module nfpi_sync #(
  parameter int W = 9
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } nfpi_sync_s;

  nfpi_sync_s s_reg;
  nfpi_sync_s s_next;

  always_comb begin
    s_next    = s_reg;
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.s2;

endmodule

// ==== nfpi_ctrl.sv ====
// Host-side controller for a byte-wide NAND flash: read page, program page,
// erase block and reset, with a per-528-byte single-bit ECC code on the data stream.
// Assumes the flash pins are joined by the testbench; the ready/busy wire is pulled up.
// What this block does
// - Command byte latched on write rise, command latch high.
// - Address byte latched on write rise, address latch high.
// - Read cycle never shorter than 30 ns.
// - First two address bytes carry 12-bit column.
// - Upper nibble of second address byte low.
// - Third and fourth address bytes carry row.
// - Allow page read busy before reading data.
// - Host computes single-bit ECC per 528 bytes.
// - Every byte written with chip select low.
// - Operations chosen by command codes, e.g. 00h/30h.
`timescale 1ns/100ps
module nfpi_ctrl
  import nfpi_pkg::*;
#(
  parameter int BUSY_LIMIT_CYC = BUSY_LIMIT_DEF
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             op_valid,
  input  wire nfpi_op_e         op,
  input  wire logic [COL_W-1:0] op_col,
  input  wire logic [ROW_W-1:0] op_row,
  input  wire logic [COL_W-1:0] op_len,
  output logic                  op_ready,
  input  wire logic [7:0]       wr_data,
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  output logic [7:0]            rd_data,
  output logic                  rd_valid,
  output logic                  done,
  output logic                  fail,
  output logic [ECC_W-1:0]      ecc_code,
  output logic                  ecc_valid,
  output nfpi_pins_s            flash_pins,
  input  wire logic [7:0]       data_pins_i,
  input  wire logic             ready_busy_n
);

  nfpi_state_s s_reg;
  nfpi_state_s s_next;
  logic [8:0]  pin_sync;

  nfpi_sync #(.W(9)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({ready_busy_n, data_pins_i}),
    .q        (pin_sync)
  );

  // Start one write-strobe cycle; the flash latches on the closing rising edge.
  function automatic nfpi_state_s wr_byte(nfpi_state_s x, logic [7:0] b, logic c, logic a);
    x.st                = ST_WLOW;
    x.cnt               = 20'(WP_CYC);
    x.pins.ce_n         = 1'b0;
    x.pins.we_n         = 1'b0;
    x.pins.cle          = c;
    x.pins.ale          = a;
    x.pins.data_pins_o  = b;
    x.pins.data_pins_oe = 1'b1;
    return x;
  endfunction

  // Start one read-strobe cycle with our driver released in the same cycle that the strobe falls and the flash drives.
  function automatic nfpi_state_s rd_byte(nfpi_state_s x);
    x.st                 = ST_RLOW;
    x.cnt                = 20'(RD_LOW_CYC);
    x.pins.read_strobe_n = 1'b0;
    x.pins.cle           = 1'b0;
    x.pins.ale           = 1'b0;
    x.pins.data_pins_oe  = 1'b0;
    return x;
  endfunction

  // Erase sends only the two row bytes, so its index starts at the row.
  function automatic logic [7:0] addr_byte(nfpi_state_s x);
    unique case ((x.opc == OP_ERASE) ? 2'(x.aidx + 2'd2) : x.aidx)
      2'd0: addr_byte = x.col[7:0];
      2'd1: addr_byte = {4'h0, x.col[11:8]};
      2'd2: addr_byte = x.row[7:0];
      2'd3: addr_byte = x.row[15:8];
    endcase
  endfunction

  function automatic logic [7:0] op_cmd(nfpi_op_e o, logic last);
    unique case (o)
      OP_READ:  op_cmd = last ? CMD_READ2 : CMD_READ1;
      OP_PROG:  op_cmd = last ? CMD_PROG2 : CMD_PROG1;
      OP_ERASE: op_cmd = last ? CMD_ERASE2 : CMD_ERASE1;
      OP_RESET: op_cmd = CMD_RESET;
    endcase
  endfunction

  // Position-xor code: a single flipped bit shows as the xor of stored and fresh code,
  // which names its byte and bit; bit 13 tells a single error from none.
  function automatic nfpi_state_s ecc_add(nfpi_state_s x, logic [7:0] b);
    if (^b) begin
      x.eacc[12:3] = x.eacc[12:3] ^ x.echk;
      x.eacc[13]   = ~x.eacc[13];
    end
    for (int i = 0; i < 8; i++) begin
      if (b[i]) x.eacc[2:0] = x.eacc[2:0] ^ 3'(i);
    end
    if (x.echk == 10'(ECC_CHUNK - 1)) begin
      x.ecode  = x.eacc;
      x.evalid = 1'b1;
      x.eacc   = '0;
      x.echk   = '0;
    end else begin
      x.echk = x.echk + 10'h001;
    end
    return x;
  endfunction

  always_comb begin
    s_next          = s_reg;
    s_next.rd_valid = 1'b0;
    s_next.done     = 1'b0;
    s_next.evalid   = 1'b0;
    s_next.wr_ready = 1'b0;
    // Timed states count down unless a branch reloads the count; ST_BUSY counts it up from zero instead, other states ignore it.
    s_next.cnt      = s_reg.cnt - 20'h00001;
    unique case (s_reg.st)
      ST_IDLE: begin
        if (op_valid) begin
          s_next.opc  = op;
          s_next.col  = op_col;
          // Page bits are cleared so an erase always names the block's first page.
          s_next.row  = (op == OP_ERASE) ? (op_row & ~16'(BLOCK_PAGES - 1)) : op_row;
          s_next.left = (op_len > 12'(PAGE_BYTES)) ? 12'(PAGE_BYTES) : op_len;
          s_next.fail = 1'b0;
          s_next.echk = '0;
          s_next.eacc = '0;
          s_next.ph   = PH_CMD1;
          // Protection is lifted only for the operations that need high voltage.
          s_next.pins.wp_n = (op == OP_PROG) || (op == OP_ERASE);
          s_next = wr_byte(s_next, op_cmd(op, 1'b0), 1'b1, 1'b0);
        end
      end
      ST_WLOW: begin
        if (s_reg.cnt <= 20'h00001) begin
          s_next.st        = ST_WHIGH;
          s_next.cnt       = 20'(WH_CYC);
          s_next.pins.we_n = 1'b1;
        end
      end
      ST_WHIGH: begin
        if (s_reg.cnt <= 20'h00001) begin
          s_next.pins.cle = 1'b0;
          s_next.pins.ale = 1'b0;
          unique case (s_reg.ph)
            PH_CMD1: begin
              if (s_reg.opc == OP_RESET) begin
                s_next.st  = ST_WAITB;
                s_next.cnt = 20'(WB_CYC);
              end else begin
                s_next.ph   = PH_ADDR;
                s_next.aidx = 2'd0;
                s_next = wr_byte(s_next, addr_byte(s_next), 1'b0, 1'b1);
              end
            end
            PH_ADDR, PH_DATA: begin
              if (s_reg.ph == PH_ADDR
                  && s_reg.aidx != ((s_reg.opc == OP_ERASE) ? 2'd1 : 2'd3)) begin
                s_next.aidx = s_reg.aidx + 2'd1;
                s_next = wr_byte(s_next, addr_byte(s_next), 1'b0, 1'b1);
              end else if (s_reg.opc == OP_PROG && s_reg.left != '0) begin
                s_next.ph       = PH_DATA;
                s_next.st       = ST_DWAIT;
                s_next.wr_ready = 1'b1;
              end else begin
                s_next.ph = PH_CMD2;
                s_next = wr_byte(s_next, op_cmd(s_reg.opc, 1'b1), 1'b1, 1'b0);
              end
            end
            PH_CMD2: begin
              s_next.st                = ST_WAITB;
              s_next.cnt               = 20'(WB_CYC);
              s_next.pins.data_pins_oe = 1'b0;
            end
            default: begin
              s_next.ph = PH_STATR;
              s_next = rd_byte(s_next);
            end
          endcase
        end
      end
      ST_DWAIT: begin
        s_next.wr_ready = 1'b1;
        if (wr_valid && s_reg.wr_ready) begin
          s_next.wr_ready = 1'b0;
          s_next.left     = s_reg.left - 12'h001;
          s_next = ecc_add(s_next, wr_data);
          s_next = wr_byte(s_next, wr_data, 1'b0, 1'b0);
        end
      end
      ST_WAITB: begin
        if (s_reg.cnt <= 20'h00001) begin
          s_next.st  = ST_BUSY;
          s_next.cnt = '0;
        end
      end
      ST_BUSY: begin
        // Chip select stays low while the flash works, though it would not care.
        if (pin_sync[8]) begin
          unique case (s_reg.opc)
            OP_READ: begin
              s_next.ph = PH_DOUT;
              if (s_reg.left != '0) begin
                s_next = rd_byte(s_next);
              end else begin
                s_next.st = ST_DONE;
              end
            end
            OP_RESET: s_next.st = ST_DONE;
            default: begin
              s_next.ph = PH_STATC;
              s_next = wr_byte(s_next, CMD_STATUS, 1'b1, 1'b0);
            end
          endcase
        end else if (s_reg.cnt == 20'(BUSY_LIMIT_CYC - 1)) begin
          s_next.fail = 1'b1;
          s_next.st   = ST_DONE;
        end else begin
          s_next.cnt = s_reg.cnt + 20'h00001;
        end
      end
      ST_RLOW: begin
        if (s_reg.cnt <= 20'h00001) begin
          s_next.st                 = ST_RHIGH;
          s_next.cnt                = 20'(RD_HIGH_CYC);
          s_next.pins.read_strobe_n = 1'b1;
          s_next.rd_data            = pin_sync[7:0];
          if (s_reg.ph == PH_DOUT) begin
            s_next.rd_valid = 1'b1;
            s_next.left     = s_reg.left - 12'h001;
            s_next = ecc_add(s_next, pin_sync[7:0]);
          end else begin
            s_next.fail = pin_sync[STATUS_FAIL_BIT];
          end
        end
      end
      ST_RHIGH: begin
        if (s_reg.cnt <= 20'h00001) begin
          s_next.st = ST_DONE;
          if (s_reg.ph == PH_DOUT && s_reg.left != '0) begin
            s_next = rd_byte(s_next);
          end
        end
      end
      ST_DONE: begin
        s_next.done = 1'b1;
        s_next.st   = ST_IDLE;
        s_next.pins = PINS_RST;
        // A short last chunk still gets its code.
        if (s_reg.echk != '0) begin
          s_next.ecode  = s_reg.eacc;
          s_next.evalid = 1'b1;
        end
      end
      default: s_next = STATE_RST;
    endcase
    s_next.op_ready = (s_next.st == ST_IDLE);
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign op_ready   = s_reg.op_ready;
  assign wr_ready   = s_reg.wr_ready;
  assign rd_data    = s_reg.rd_data;
  assign rd_valid   = s_reg.rd_valid;
  assign done       = s_reg.done;
  assign fail       = s_reg.fail;
  assign ecc_code   = s_reg.ecode;
  assign ecc_valid  = s_reg.evalid;
  assign flash_pins = s_reg.pins;

endmodule

// ==== nfpi_ctrl_props.sv ====
// Concurrent checks on the flash pins and user port of the NAND pin controller.
// Assumes a single core_clk domain with rst asynchronous and active high.
`timescale 1ns/100ps
module nfpi_ctrl_props
  import nfpi_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       op_valid,
  input wire nfpi_op_e   op,
  input wire logic       op_ready,
  input wire logic       done,
  input wire nfpi_pins_s flash_pins,
  input wire logic       ready_busy_n
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic [7:0] last_cmd;
  logic [2:0] abyte;

  // The byte index only matters for the nibble check, so it may wrap past seven.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      last_cmd <= 8'h00;
      abyte    <= 3'h0;
    end else if ($rose(flash_pins.we_n) && flash_pins.cle) begin
      last_cmd <= flash_pins.data_pins_o;
      abyte    <= 3'h0;
    end else if ($rose(flash_pins.we_n) && flash_pins.ale) begin
      abyte <= abyte + 3'h1;
    end
  end

  sequence s_wlow;
    !flash_pins.we_n && $stable(flash_pins.data_pins_o) && $stable(flash_pins.cle)
      && $stable(flash_pins.ale);
  endsequence
  sequence s_whigh;
    flash_pins.we_n && $stable(flash_pins.data_pins_o) && $stable(flash_pins.cle);
  endsequence

  property p_we_pulse;
    $fell(flash_pins.we_n) |=> s_wlow ##1 s_whigh;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe pulse malformed");
  property p_we_ce;
    !flash_pins.we_n |-> !flash_pins.ce_n;
  endproperty
  a_we_ce: assert property (p_we_ce) else $error("write strobe without chip select");
  property p_latch;
    !(flash_pins.cle && flash_pins.ale);
  endproperty
  a_latch: assert property (p_latch) else $error("both latch strobes high");
  property p_rd_low;
    $fell(flash_pins.read_strobe_n) |-> (!flash_pins.read_strobe_n) [*4] ##1
      flash_pins.read_strobe_n;
  endproperty
  a_rd_low: assert property (p_rd_low) else $error("read strobe period wrong");
  property p_rd_quiet;
    !flash_pins.read_strobe_n |-> !flash_pins.ce_n && !flash_pins.cle && !flash_pins.ale
      && !flash_pins.data_pins_oe && flash_pins.we_n;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("pins wrong in read");
  property p_col_hi;
    $fell(flash_pins.we_n) && flash_pins.ale && abyte == 3'h1 && last_cmd != CMD_ERASE1
      |-> flash_pins.data_pins_o[7:4] == 4'h0;
  endproperty
  a_col_hi: assert property (p_col_hi) else $error("upper column nibble not low");
  property p_busy_rd;
    !ready_busy_n |-> flash_pins.read_strobe_n;
  endproperty
  a_busy_rd: assert property (p_busy_rd) else $error("read strobe while busy");
  property p_wp;
    $rose(flash_pins.wp_n) |-> $past(op_valid && op_ready && (op == OP_PROG || op == OP_ERASE));
  endproperty
  a_wp: assert property (p_wp) else $error("write protect lifted for wrong op");
  property p_take;
    op_valid && op_ready |=> !op_ready && !flash_pins.ce_n && flash_pins.cle && !flash_pins.we_n;
  endproperty
  a_take: assert property (p_take) else $error("op not started by a command");
  property p_done;
    done |=> !done;
  endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
endmodule

bind nfpi_ctrl nfpi_ctrl_props u_props (
  .core_clk     (core_clk),
  .rst          (rst),
  .op_valid     (op_valid),
  .op           (op),
  .op_ready     (op_ready),
  .done         (done),
  .flash_pins   (flash_pins),
  .ready_busy_n (ready_busy_n)
);

// ==== nfpi_flash_model.sv ====
// Behavioural NAND flash device seen from its pins; it has no clock of its own.
// Assumes the controller drives the strobes; ready/busy is open drain with a pull-up.
`timescale 1ns/100ps
module nfpi_flash_model
  import nfpi_pkg::*;
#(
  parameter int BUSY_NS = 1000
) (
  input  wire nfpi_pins_s pins,
  output logic [7:0]      data_level,
  output logic            ready_busy_n
);
  logic [7:0]  mem [int];
  logic [7:0]  pbuf [int];
  logic [7:0]  cmd   = 8'h00;
  logic [7:0]  dout  = 8'h00;
  logic [7:0]  hold  = 8'h00;
  logic [11:0] col   = 12'h000;
  logic [15:0] row   = 16'h0000;
  logic        busy  = 1'b0;
  logic        sfail = 1'b0;
  int          ai    = 4;
  int          dead [$];
  wire         drive = !pins.ce_n && !pins.read_strobe_n;

  // A floating bus shows the inverse of its last level so stale data never matches.
  always @* if (pins.data_pins_oe) hold = pins.data_pins_o; else if (drive) hold = dout;
  assign data_level   = pins.data_pins_oe ? pins.data_pins_o : (drive ? dout : ~hold);
  assign ready_busy_n = !busy;

  always @(posedge pins.we_n) begin
    if (!pins.ce_n) begin
      if (pins.cle) begin
        cmd = pins.data_pins_o;
        ai = (cmd == CMD_ERASE1) ? 2 : 0;
        if (cmd == CMD_PROG1) pbuf.delete();
        if (cmd == CMD_PROG2 || cmd == CMD_ERASE2) sfail = !pins.wp_n;
        if (cmd == CMD_PROG2 && pins.wp_n) begin
          foreach (pbuf[k]) mem[int'({row, 12'h000}) + k] = pbuf[k];
        end
        if (cmd == CMD_ERASE2 && pins.wp_n) begin
          foreach (mem[k]) if (k[27:18] == row[15:6]) dead.push_back(k);
          foreach (dead[i]) mem.delete(dead[i]);
          dead.delete();
        end
        // Busy runs on regardless of chip select.
        if (cmd == CMD_READ2 || cmd == CMD_PROG2 || cmd == CMD_ERASE2 || cmd == CMD_RESET) begin
          fork
            begin
              busy = 1'b1;
              #(BUSY_NS);
              busy = 1'b0;
            end
          join_none
        end
      end else if (pins.ale) begin
        if (ai == 0) col[7:0] = pins.data_pins_o;
        else if (ai == 1) col[11:8] = pins.data_pins_o[3:0];
        else if (ai == 2) row[7:0] = pins.data_pins_o;
        else if (ai == 3) row[15:8] = pins.data_pins_o;
        ai++;
      end else begin
        pbuf[col] = pins.data_pins_o;
        col++;
      end
    end
  end

  // Output is instant, so any strobe rate the host picks is sustained.
  always @(negedge pins.read_strobe_n) begin
    if (!pins.ce_n && cmd == CMD_STATUS) begin
      dout = {!busy, 6'h00, sfail};
    end else if (!pins.ce_n) begin
      dout = mem.exists(int'({row, col})) ? mem[int'({row, col})] : 8'hff;
      col++;
    end
  end
endmodule

// ==== nfpi_ctrl_test.sv ====
// Self-checking bench: program, read back, erase and reset through the user port.
// Assumes the flash model on the pins; inputs change on the falling clock edge.
`timescale 1ns/100ps
module nfpi_ctrl_test
  import nfpi_pkg::*;
;
  logic             core_clk = 1'b0;
  logic             rst      = 1'b1;
  logic             op_valid = 1'b0;
  nfpi_op_e         op       = OP_READ;
  logic [COL_W-1:0] op_col   = 12'h000;
  logic [ROW_W-1:0] op_row   = 16'h0000;
  logic [COL_W-1:0] op_len   = 12'h000;
  logic [7:0]       wr_data  = 8'h00;
  logic             wr_valid = 1'b0;
  logic             op_ready, wr_ready, rd_valid, done, fail, ecc_valid, ready_busy_n;
  logic [7:0]       rd_data, data_level;
  logic [ECC_W-1:0] ecc_code;
  nfpi_pins_s       flash_pins;
  int               failures = 0;
  int               n_checks = 0;
  int               cycles   = 0;
  int               ecc_n;
  logic [7:0]       rq [$];

  nfpi_ctrl #(.BUSY_LIMIT_CYC(2000)) dut (
    .core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op(op), .op_col(op_col),
    .op_row(op_row), .op_len(op_len), .op_ready(op_ready), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .fail(fail), .ecc_code(ecc_code), .ecc_valid(ecc_valid),
    .flash_pins(flash_pins), .data_pins_i(data_level), .ready_busy_n(ready_busy_n));
  nfpi_flash_model u_flash (.pins(flash_pins), .data_level(data_level),
    .ready_busy_n(ready_busy_n));

  always #10 core_clk = ~core_clk;

  task report_and_stop;
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  function automatic logic [7:0] pat(input int r, input int i);
    return 8'(r * 13 + i * 7 + 1);
  endfunction

  // Expected chunk code: odd-parity byte indices, set-bit positions, overall parity.
  function automatic logic [ECC_W-1:0] ecc_of(input int r, input int n, input bit erased);
    logic [ECC_W-1:0] e;
    logic [7:0]       b;
    e = '0;
    for (int i = 0; i < n; i++) begin
      b = erased ? 8'hff : pat(r, i);
      if (^b) begin
        e[12:3] = e[12:3] ^ 10'(i);
        e[13]   = ~e[13];
      end
      for (int j = 0; j < 8; j++) begin
        if (b[j]) e[2:0] = e[2:0] ^ 3'(j);
      end
    end
    return e;
  endfunction

  // A byte counts as taken one cycle after wr_ready was seen, so data changes safely.
  task run(input nfpi_op_e o, input logic [15:0] r, input logic [11:0] c, input logic [11:0] n);
    int k;
    int took;
    int t;
    rq.delete();
    ecc_n = 0;
    k = 0;
    took = 0;
    @(negedge core_clk);
    op = o;
    op_row = r;
    op_col = c;
    op_len = n;
    op_valid = 1'b1;
    wr_valid = 1'b1;
    wr_data = pat(r, 0);
    while (op_ready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    op_valid = 1'b0;
    for (t = 0; t < 5000 && done !== 1'b1; t++) begin
      if (took != 0) begin
        k++;
        wr_data = pat(r, k);
      end
      took = (wr_ready === 1'b1);
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (ecc_valid === 1'b1) ecc_n++;
      @(negedge core_clk);
    end
    // The code of a short last chunk comes out in the same cycle as done.
    if (ecc_valid === 1'b1) ecc_n++;
    wr_valid = 1'b0;
    check(16'(done), 16'h0001, "operation did not finish");
    check(16'(fail), 16'h0000, "operation reported failure");
  endtask

  task read_back(input logic [15:0] r, input logic [11:0] c, input int n, input bit erased);
    run(OP_READ, r, c, 12'(n));
    check(16'(rq.size()), 16'(n), "read byte count");
    check(16'(ecc_n), 16'h0001, "ecc code pulses");
    check(16'(ecc_code), 16'(ecc_of(r, n, erased)), "ecc code value");
    for (int i = 0; i < n && i < rq.size(); i++) begin
      check(16'(rq[i]), erased ? 16'h00ff : 16'(pat(r, i)), "read data");
    end
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("CHECK FAILED %0t run too long", $time);
      report_and_stop;
    end
  end

  initial begin
    repeat (12) @(negedge core_clk);
    check(16'(flash_pins.ce_n), 16'h0001, "chip select in reset");
    check(16'(flash_pins.wp_n), 16'h0000, "write protect in reset");
    check(16'(flash_pins.data_pins_oe), 16'h0000, "bus drive in reset");
    check(16'(op_ready), 16'h0001, "ready in reset");
    rst = 1'b0;
    // Columns near the page end exercise the upper column nibble.
    run(OP_PROG, 16'h0041, 12'h83c, 12'h004);
    run(OP_PROG, 16'h0080, 12'h000, 12'h003);
    read_back(16'h0041, 12'h83c, 4, 1'b0);
    run(OP_ERASE, 16'h0045, 12'h000, 12'h000);
    read_back(16'h0041, 12'h83c, 2, 1'b1);
    read_back(16'h0080, 12'h000, 3, 1'b0);
    run(OP_RESET, 16'h0000, 12'h000, 12'h000);
    report_and_stop;
  end
endmodule
